// file: rtl/ssml_link.sv
`timescale 1ns/1ps
module ssml_link import ssml_pkg::*; (
  input  wire logic        pclk,                // System clock
  input  wire logic        presetn,             // Async reset, active low
  input  wire logic [7:0]  paddr,               // APB address
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB enable
  input  wire logic        pwrite,              // APB direction
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error
  input  wire logic        port_mode_select,    // High: sync mode
  input  wire logic        flow_mode_select,    // 0 byte, 1 bit
  input  wire logic        sleep_in,            // Sleep request
  input  wire logic        suspend_in,          // Suspend request
  input  wire logic        host_ready_n,        // Host ready, low
  input  wire logic        host_msg_pending_n,  // Host has message
  input  wire logic        device_serial_in,    // Serial data in
  output logic             device_serial_out,   // Serial data out
  output logic             serial_clk,          // Serial clock out
  output logic             transfer_begin_n,    // Transfer open, low
  output logic             low_power            // Suspended
);

  typedef enum logic [2:0] {M_IDLE, M_BEGIN, M_SHIFT, M_NEXT} ssml_m_st_t;

  // Pin synchronisers
  logic [SYNC_N-1:0] pin_raw;   // Raw pin vector
  logic [SYNC_N-1:0] meta_ff;   // First stage, read by second only
  logic [SYNC_N-1:0] pin_ff;    // Second stage, safe to use
  logic              susp_d_ff; // Suspend delayed for edge

  // Link control state
  ssml_m_st_t  st_ff,    nxt_st;     // Message phase
  logic        dir_ff,   nxt_dir;    // 1: host to device
  logic [3:0]  idx_ff,   nxt_idx;    // Byte index in frame
  logic [7:0]  csum_ff,  nxt_csum;   // Running XOR
  logic        sen_n_ff;             // Begin line register
  logic        start_sh;             // Kick the shifter
  logic        fin_tx;               // Device message sent
  logic        fin_ok;               // Host message good
  logic        fin_bad;              // Host message rejected

  // Software-visible registers
  logic [7:0]  tx_len_ff;            // Outgoing length
  logic [7:0]  tx_id_ff;             // Outgoing identifier
  logic [7:0]  tx_mem [MAX_DATA];    // Outgoing data
  logic [7:0]  rx_len_ff;            // Received length
  logic [7:0]  rx_id_ff;             // Received identifier
  logic [7:0]  rx_mem [MAX_DATA];    // Received data
  logic        busy_ff;              // Send requested or running
  logic        rxv_ff;               // Good message waiting
  logic        rxbad_ff;             // Message dropped
  logic [31:0] prdata_ff;            // Registered read data

  ssml_shift_if sh_if ();

  // Two flip-flops for every pin before any logic
  assign pin_raw = {device_serial_in, host_msg_pending_n, host_ready_n,
                    suspend_in, sleep_in, flow_mode_select,
                    port_mode_select};
  generate
    for (genvar gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff[gi] <= SYNC_RST[gi];
          pin_ff[gi]  <= SYNC_RST[gi];
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          pin_ff[gi]  <= meta_ff[gi];
        end
      end
    end
  endgenerate

  wire sync_mode  = pin_ff[IX_PORT];
  wire bit_flow   = pin_ff[IX_FLOW];
  wire sleep_s    = pin_ff[IX_SLEEP];
  wire susp_s     = pin_ff[IX_SUSP];
  wire host_rdy   = !pin_ff[IX_RDY_N];
  wire host_pend  = !pin_ff[IX_PEND_N];

  // Suspend only counts while sleep is high; only sleep low ends it
  wire nxt_lp     = sleep_s & (low_power | susp_s);
  // Suspend edge without sleep resets, outside synchronous mode only
  wire rst_pulse  = susp_s & !susp_d_ff & !sleep_s & !sync_mode;
  // Kill holds the sequencer, APB registers and shifter pins at power-up values, effective at once
  wire kill       = low_power | rst_pulse;

  // Power state and suspend edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power <= 1'b0;
      susp_d_ff <= 1'b0;
    end else begin
      low_power <= nxt_lp;
      susp_d_ff <= susp_s;
    end
  end

  // Frame decode
  wire [7:0] cur_len  = dir_ff ? rx_len_ff : tx_len_ff;
  wire [3:0] last_idx = cur_len[3:0] + HDR_BYTES;
  wire       is_last  = (idx_ff > HDR_BYTES) && (idx_ff == last_idx);
  wire [3:0] data_idx = idx_ff - HDR_BYTES;
  wire [7:0] sync_b   = dir_ff ? SYNC_H2D : SYNC_D2H;
  wire [7:0] data_b   = (data_idx < 4'(MAX_DATA)) ? tx_mem[data_idx] : RST_BYTE;
  wire [7:0] cur_tx   = (idx_ff == 4'h0) ? sync_b    :
                        dir_ff           ? IDLE_BYTE :
                        (idx_ff == 4'h1) ? tx_len_ff :
                        (idx_ff == 4'h2) ? tx_id_ff  :
                        is_last          ? csum_ff   : data_b;
  wire       rx_phase = dir_ff && (idx_ff != 4'h0);   // Half duplex
  wire [7:0] got_byte = rx_phase ? sh_if.rx_byte : cur_tx;
  wire       byte_end = (st_ff == M_SHIFT) && sh_if.done;
  wire       len_bad  = (sh_if.rx_byte < LEN_MIN) || (sh_if.rx_byte > LEN_MAX);
  wire       rx_wr    = byte_end && rx_phase;

  // Message sequencer
  always_comb begin
    nxt_st   = st_ff;
    nxt_dir  = dir_ff;
    nxt_idx  = idx_ff;
    nxt_csum = csum_ff;
    start_sh = 1'b0;
    fin_tx   = 1'b0;
    fin_ok   = 1'b0;
    fin_bad  = 1'b0;
    case (st_ff)
      M_IDLE: if (sync_mode) begin
        nxt_idx  = 4'h0;
        nxt_csum = RST_BYTE;
        if (host_pend) begin                          // Host asks first
          nxt_dir = 1'b1;
          nxt_st  = M_BEGIN;
        end else if (busy_ff) begin
          nxt_dir = 1'b0;
          nxt_st  = M_BEGIN;
        end
      end
      M_BEGIN: if (host_rdy) begin                    // Begin and ready
        start_sh = 1'b1;
        nxt_st   = M_SHIFT;
      end
      M_SHIFT: if (sh_if.done) begin
        nxt_csum = csum_ff ^ got_byte;
        nxt_idx  = idx_ff + 4'h1;
        nxt_st   = M_NEXT;
        if (rx_phase && idx_ff == 4'h1 && len_bad) begin
          fin_bad = 1'b1;                             // Length out of range
          nxt_st  = M_IDLE;
        end else if (is_last) begin
          nxt_st  = M_IDLE;
          fin_tx  = !dir_ff;
          fin_ok  = dir_ff && (sh_if.rx_byte == csum_ff);
          fin_bad = dir_ff && (sh_if.rx_byte != csum_ff);
        end
      end
      // Byte flow waits for ready per byte; bit flow gates each bit
      M_NEXT: if (bit_flow || host_rdy) begin
        start_sh = 1'b1;
        nxt_st   = M_SHIFT;
      end
      default: nxt_st = M_IDLE;
    endcase
  end

  // Sequencer registers, cleared by suspend or reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff    <= M_IDLE;
      dir_ff   <= 1'b0;
      idx_ff   <= 4'h0;
      csum_ff  <= RST_BYTE;
      sen_n_ff <= 1'b1;
    end else if (kill) begin
      st_ff    <= M_IDLE;
      dir_ff   <= 1'b0;
      idx_ff   <= 4'h0;
      csum_ff  <= RST_BYTE;
      sen_n_ff <= 1'b1;
    end else begin
      st_ff    <= nxt_st;
      dir_ff   <= nxt_dir;
      idx_ff   <= nxt_idx;
      csum_ff  <= nxt_csum;
      sen_n_ff <= (nxt_st == M_IDLE);
    end
  end

  // Shifter hookup; the device supplies the serial clock
  assign sh_if.start    = start_sh && !kill;
  assign sh_if.tx_byte  = cur_tx;
  assign sh_if.bit_mode = bit_flow && (st_ff == M_SHIFT);
  assign sh_if.bit_ok   = host_rdy;
  assign sh_if.abort    = kill;
  assign sh_if.rx_in    = pin_ff[IX_SIN];

  ssml_shifter u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .sh      (sh_if.shifter)
  );

  assign serial_clk        = sh_if.sclk;
  assign device_serial_out = sh_if.sdo;
  assign transfer_begin_n  = sen_n_ff;

  // APB decode, zero wait states
  wire       acc      = psel & penable;
  wire       wr_en    = acc & pwrite;
  wire [3:0] word     = paddr[5:2];
  wire       mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFS_LAST);
  wire       hit_ctrl = mapped && (paddr == OFS_CTRL);
  wire       hit_thdr = mapped && (paddr == OFS_TX_HDR);
  wire       hit_stat = mapped && (paddr == OFS_STATUS);
  wire       go_ok    = sync_mode && !busy_ff && (tx_len_ff >= LEN_MIN) &&
                        (tx_len_ff <= LEN_MAX);
  wire       go_set   = wr_en && hit_ctrl && pwdata[CTRL_GO_BIT] && go_ok;
  wire       cfg_wr   = wr_en && !busy_ff;            // Frozen while sending

  assign pready  = acc;
  assign pslverr = acc & !mapped;
  assign prdata  = prdata_ff;

  // Byte views for the data words, unused lanes read zero
  logic [7:0] txb [12];
  logic [7:0] rxb [12];
  generate
    for (genvar gk = 0; gk < 12; gk++) begin : g_bytes
      if (gk < MAX_DATA) begin : g_mem
        wire [3:0] tword = 4'(OFS_TXD0[7:2]) + 4'(gk / 4);
        wire       twe   = cfg_wr && mapped && (word == tword);
        assign txb[gk] = tx_mem[gk];
        assign rxb[gk] = rx_mem[gk];
        // Outgoing data byte
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            tx_mem[gk] <= RST_BYTE;
          end else if (kill) begin
            tx_mem[gk] <= RST_BYTE;
          end else if (twe) begin
            tx_mem[gk] <= pwdata[8*(gk%4) +: 8];
          end
        end
        // Incoming data byte, written as it arrives
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            rx_mem[gk] <= RST_BYTE;
          end else if (kill) begin
            rx_mem[gk] <= RST_BYTE;
          end else if (rx_wr && !is_last && data_idx == 4'(gk) &&
                       idx_ff > 4'h2) begin
            rx_mem[gk] <= sh_if.rx_byte;
          end
        end
      end else begin : g_pad
        assign txb[gk] = RST_BYTE;
        assign rxb[gk] = RST_BYTE;
      end
    end
  endgenerate

  // Read selection
  wire [3:0]  w_txd0 = 4'(OFS_TXD0[7:2]);
  wire [3:0]  w_rxd0 = 4'(OFS_RXD0[7:2]);
  wire [3:0]  tsel   = word - w_txd0;
  wire [3:0]  rsel   = word - w_rxd0;
  wire [31:0] txd_w  = {txb[4*tsel[1:0]+3], txb[4*tsel[1:0]+2],
                        txb[4*tsel[1:0]+1], txb[4*tsel[1:0]]};
  wire [31:0] rxd_w  = {rxb[4*rsel[1:0]+3], rxb[4*rsel[1:0]+2],
                        rxb[4*rsel[1:0]+1], rxb[4*rsel[1:0]]};
  wire [31:0] stat_w = 32'(busy_ff)              << ST_BUSY_BIT  |
                       32'(rxv_ff)               << ST_RXV_BIT   |
                       32'(rxbad_ff)             << ST_RXBAD_BIT |
                       32'(sync_mode)            << ST_SYNC_BIT  |
                       32'(bit_flow)             << ST_FLOW_BIT  |
                       32'(low_power)            << ST_LP_BIT;
  wire        in_txd = (word >= w_txd0) && (tsel < 4'h3);
  wire        in_rxd = (word >= w_rxd0) && (rsel < 4'h3);
  wire [31:0] rd_w   = !mapped  ? 32'h0000_0000 :
                       hit_ctrl ? 32'(busy_ff) << CTRL_GO_BIT :
                       hit_thdr ? {16'h0000, tx_id_ff, tx_len_ff} :
                       hit_stat ? stat_w :
                       (paddr == OFS_RX_HDR) ? {16'h0000, rx_id_ff, rx_len_ff} :
                       in_txd   ? txd_w :
                       in_rxd   ? rxd_w : 32'h0000_0000;

  // Read data caught in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (kill || (psel && !penable && !pwrite)) begin
      prdata_ff <= kill ? 32'h0000_0000 : rd_w;
    end
  end

  // Header and busy registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_len_ff <= RST_BYTE;
      tx_id_ff  <= RST_BYTE;
      busy_ff   <= 1'b0;
    end else if (kill) begin
      tx_len_ff <= RST_BYTE;
      tx_id_ff  <= RST_BYTE;
      busy_ff   <= 1'b0;
    end else begin
      if (cfg_wr && hit_thdr) begin
        tx_len_ff <= pwdata[7:0];
        tx_id_ff  <= pwdata[15:8];
      end
      if (go_set) begin
        busy_ff <= 1'b1;
      end else if (fin_tx) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Received header and sticky status; hardware set beats W1C clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_len_ff <= RST_BYTE;
      rx_id_ff  <= RST_BYTE;
      rxv_ff    <= 1'b0;
      rxbad_ff  <= 1'b0;
    end else if (kill) begin
      rx_len_ff <= RST_BYTE;
      rx_id_ff  <= RST_BYTE;
      rxv_ff    <= 1'b0;
      rxbad_ff  <= 1'b0;
    end else begin
      if (rx_wr && idx_ff == 4'h1) begin
        rx_len_ff <= sh_if.rx_byte;
      end
      if (rx_wr && idx_ff == 4'h2) begin
        rx_id_ff <= sh_if.rx_byte;
      end
      if (fin_ok) begin
        rxv_ff <= 1'b1;
      end else if (wr_en && hit_stat && pwdata[ST_RXV_BIT]) begin
        rxv_ff <= 1'b0;
      end else if (rx_wr && idx_ff == 4'h1) begin
        rxv_ff <= 1'b0;                               // New message overwrites
      end
      if (fin_bad) begin
        rxbad_ff <= 1'b1;
      end else if (wr_en && hit_stat && pwdata[ST_RXBAD_BIT]) begin
        rxbad_ff <= 1'b0;
      end
    end
  end

endmodule : ssml_link

// file: pkg/ssml_pkg.sv
package ssml_pkg;

  // APB register byte offsets (aligned words; TXD0 and RXD0 each start a run of three words)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TX_HDR = 8'h04;
  localparam logic [7:0] OFS_TXD0   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RX_HDR = 8'h18;
  localparam logic [7:0] OFS_RXD0   = 8'h1C;
  localparam logic [7:0] OFS_LAST   = 8'h24;

  // Field positions
  localparam int CTRL_GO_BIT  = 0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_RXV_BIT   = 1;
  localparam int ST_RXBAD_BIT = 2;
  localparam int ST_SYNC_BIT  = 3;
  localparam int ST_FLOW_BIT  = 4;
  localparam int ST_LP_BIT    = 5;

  // Frame constants
  localparam logic [7:0] SYNC_D2H  = 8'hA4;
  localparam logic [7:0] SYNC_H2D  = 8'hA5;
  localparam logic [7:0] LEN_MIN   = 8'h01;
  localparam logic [7:0] LEN_MAX   = 8'h09;
  localparam int         MAX_DATA  = 9;
  localparam logic [3:0] HDR_BYTES = 4'h3;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // Link clock timing, half period of the serial clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_HALF_NS  = 80;
  localparam int HALF_CYC      = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int HALF_W        = $clog2(HALF_CYC + 1);

  // Synchroniser layout for pin inputs
  localparam int         SYNC_N     = 7;
  localparam int         IX_PORT    = 0;
  localparam int         IX_FLOW    = 1;
  localparam int         IX_SLEEP   = 2;
  localparam int         IX_SUSP    = 3;
  localparam int         IX_RDY_N   = 4;
  localparam int         IX_PEND_N  = 5;
  localparam int         IX_SIN     = 6;
  localparam logic [6:0] SYNC_RST   = 7'h70;

endpackage : ssml_pkg

// file: pkg/ssml_shift_if.sv
`timescale 1ns/1ps
interface ssml_shift_if;
  logic       start;     // Begin one byte
  logic [7:0] tx_byte;   // Byte to shift out
  logic       bit_mode;  // Per-bit handshake
  logic       bit_ok;    // Host ready level
  logic       abort;     // Kill the byte at once
  logic       rx_in;     // Synchronised serial input
  logic       busy;      // Byte in flight
  logic       done;      // One-cycle end of byte
  logic [7:0] rx_byte;   // Byte shifted in
  logic       sclk;      // Serial clock level
  logic       sdo;       // Serial data out level

  modport ctrl (output start, tx_byte, bit_mode, bit_ok, abort, rx_in,
                input  busy, done, rx_byte, sclk, sdo);
  modport shifter (input  start, tx_byte, bit_mode, bit_ok, abort, rx_in,
                   output busy, done, rx_byte, sclk, sdo);
endinterface : ssml_shift_if

// file: rtl/ssml_shifter.sv
`timescale 1ns/1ps
module ssml_shifter import ssml_pkg::*; (
  input wire logic      pclk,     // System clock
  input wire logic      presetn,  // Async reset, active low
  ssml_shift_if.shifter sh        // Byte control
);

  typedef enum logic [1:0] {SH_IDLE, SH_WAIT, SH_LOW, SH_HIGH} ssml_sh_st_t;

  ssml_sh_st_t       st_ff,   nxt_st;    // Shift phase
  logic [HALF_W-1:0] cnt_ff,  nxt_cnt;   // Half-period counter
  logic [2:0]        bit_ff,  nxt_bit;   // Bit index, lsb first
  logic [7:0]        tx_ff,   nxt_tx;    // Outgoing byte
  logic [7:0]        rx_ff,   nxt_rx;    // Incoming byte
  logic              sclk_ff, nxt_sclk;  // Clock pin level
  logic              sdo_ff,  nxt_sdo;   // Data pin level
  logic              done_ff, nxt_done;  // End-of-byte pulse

  wire half_end = (cnt_ff == HALF_W'(HALF_CYC - 1));
  // Bit mode holds each bit until the host shows ready
  wire bit_go   = !sh.bit_mode || sh.bit_ok;

  // Next-state logic of the byte shifter
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff + HALF_W'(1);
    nxt_bit  = bit_ff;
    nxt_tx   = tx_ff;
    nxt_rx   = rx_ff;
    nxt_sclk = sclk_ff;
    nxt_sdo  = sdo_ff;
    nxt_done = 1'b0;
    case (st_ff)
      SH_IDLE: if (sh.start) begin           // Load new byte
        nxt_tx  = sh.tx_byte;
        nxt_bit = 3'd0;
        nxt_st  = SH_WAIT;
      end
      SH_WAIT: if (bit_go) begin             // Falling edge, new bit
        nxt_sclk = 1'b0;
        nxt_sdo  = tx_ff[bit_ff];            // Lsb goes first
        nxt_cnt  = '0;
        nxt_st   = SH_LOW;
      end
      SH_LOW: if (half_end) begin            // Rising edge, sample
        nxt_sclk = 1'b1;
        nxt_rx   = {sh.rx_in, rx_ff[7:1]};   // Lsb arrives first
        nxt_cnt  = '0;
        nxt_st   = SH_HIGH;
      end
      SH_HIGH: if (half_end) begin           // High half complete
        if (bit_ff == 3'd7) begin
          nxt_done = 1'b1;
          nxt_st   = SH_IDLE;
        end else begin
          nxt_bit = bit_ff + 3'd1;
          nxt_st  = SH_WAIT;
        end
      end
      default: nxt_st = SH_IDLE;
    endcase
    if (sh.abort) begin                      // Suspend stops the link
      nxt_st   = SH_IDLE;
      nxt_sclk = 1'b1;
      nxt_sdo  = 1'b1;
      nxt_done = 1'b0;
    end
  end

  // State registers; clock idles high, data resets high and keeps its last bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff   <= SH_IDLE;
      cnt_ff  <= '0;
      bit_ff  <= 3'd0;
      tx_ff   <= RST_BYTE;
      rx_ff   <= RST_BYTE;
      sclk_ff <= 1'b1;
      sdo_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      bit_ff  <= nxt_bit;
      tx_ff   <= nxt_tx;
      rx_ff   <= nxt_rx;
      sclk_ff <= nxt_sclk;
      sdo_ff  <= nxt_sdo;
      done_ff <= nxt_done;
    end
  end

  assign sh.busy    = (st_ff != SH_IDLE);
  assign sh.done    = done_ff;
  assign sh.rx_byte = rx_ff;
  assign sh.sclk    = sclk_ff;
  assign sh.sdo     = sdo_ff;

endmodule : ssml_shifter

// file: testbench/ssml_link_monitor.sv
`timescale 1ns/1ps
module ssml_link_monitor import ssml_pkg::*; (
  input wire logic pclk,              // Clock
  input wire logic presetn,           // Reset, low
  input wire logic sleep_in,          // Sleep pin
  input wire logic suspend_in,        // Suspend pin
  input wire logic port_mode_select,  // Sync mode
  input wire logic device_serial_out, // Data out
  input wire logic serial_clk,        // Link clock
  input wire logic transfer_begin_n,  // Frame open, low
  input wire logic low_power          // Suspended
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_quiet_in_lp: assert property (
    low_power[*2] |-> transfer_begin_n && serial_clk) else $error("busy");
  a_lp_needs_sleep: assert property (
    $rose(low_power) |-> $past(sleep_in, 2) || $past(sleep_in, 3))
    else $error("suspend without sleep");
  a_lp_at_once: assert property (
    (sleep_in && suspend_in)[*4] |-> ##[0:2] low_power) else $error("late");
  a_lp_hold: assert property (
    sleep_in[*3] ##0 low_power |=> low_power) else $error("left early");
  // Low phase is fixed; only suspension may cut it short
  a_sclk_low16: assert property (@(posedge pclk)
    disable iff (!presetn || low_power) $fell(serial_clk) |->
    (!serial_clk)[*8] ##1 (!serial_clk)[*8] ##1 serial_clk)
    else $error("clock low phase");
  a_data_at_fall: assert property (
    $changed(device_serial_out) && !transfer_begin_n |-> $fell(serial_clk))
    else $error("data moved off the fall");
  a_begin_first: assert property (
    $fell(serial_clk) |-> !transfer_begin_n) else $error("clock outside frame");
  a_async_idle: assert property (
    (!port_mode_select)[*8] |-> transfer_begin_n) else $error("frame in async");
endmodule : ssml_link_monitor

bind ssml_link ssml_link_monitor i_ssml_link_monitor (.pclk, .presetn,
  .sleep_in, .suspend_in, .port_mode_select, .device_serial_out,
  .serial_clk, .transfer_begin_n, .low_power);

// file: testbench/ssml_host_model.sv
`timescale 1ns/1ps
module ssml_host_model import ssml_pkg::*; (
  input  wire logic        serial_clk,         // Link clock
  input  wire logic        transfer_begin_n,   // Frame open, low
  input  wire logic        device_serial_out,  // Device data
  input  wire logic        req,                // Host has a message
  input  wire logic        stall,              // Hold off ready
  input  wire logic [31:0] h2d_msg,            // len, id, d0, chk
  output logic             host_ready_n,       // Ready, low
  output logic             host_msg_pending_n, // Pending, low
  output logic             device_serial_in,   // Host data
  output logic      [47:0] rx_word             // Last bytes seen
);
  logic       tx_mode = 1'b0; // Host owns the data line
  logic [5:0] nb      = '0;   // Bits seen this frame
  logic [4:0] k       = '0;   // Bits sent
  // Ready only inside a frame, so a stall holds the link
  assign host_ready_n = transfer_begin_n | stall;
  assign host_msg_pending_n = !(req && !tx_mode);
  initial device_serial_in = 1'b1;
  // Sample device bytes LSB first at the rise
  always @(posedge serial_clk) if (!transfer_begin_n && !tx_mode) begin
    rx_word <= {device_serial_out, rx_word[47:1]};
    nb <= nb + 6'h01;
    if (nb == 6'h07 && {device_serial_out, rx_word[47:41]} == SYNC_H2D)
      tx_mode <= 1'b1;
  end
  // Own bytes change at the fall
  always @(negedge serial_clk) if (tx_mode) begin
    device_serial_in <= h2d_msg[k];
    k <= k + 5'h01;
  end
  // Released line shows the inverse, never a stale bit
  always @(posedge transfer_begin_n) begin
    tx_mode <= 1'b0;
    nb <= '0;
    k <= '0;
    device_serial_in <= ~device_serial_in;
  end
endmodule : ssml_host_model

// file: testbench/ssml_link_tb.sv
`timescale 1ns/1ps
module ssml_link_tb import ssml_pkg::*;;
  typedef struct packed {logic fl; logic [7:0] len, id; logic [95:0] d;}
    ssml_row_t;
  ssml_row_t rows[3] = '{'{1'b0, 8'h01, 8'h4B, 96'h01},
    '{1'b1, 8'h02, 8'h52, 96'h0301},
    '{1'b0, 8'h09, 8'h52, 96'h090807060504030201}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic port_mode_select = 1, flow_mode_select = 0, sleep_in = 0;
  logic suspend_in = 0, req = 0, stall = 0, pready, pslverr, low_power;
  logic host_ready_n, host_msg_pending_n, device_serial_in;
  logic device_serial_out, serial_clk, transfer_begin_n;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, h2d = '0;
  logic [47:0] rx_word;
  int mismatches = 0, n_tests = 0, nfall = 0;
  ssml_link i_ssml_link (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .port_mode_select,
    .flow_mode_select, .sleep_in, .suspend_in, .host_ready_n,
    .host_msg_pending_n, .device_serial_in, .device_serial_out,
    .serial_clk, .transfer_begin_n, .low_power);
  ssml_host_model i_ssml_host_model (.serial_clk, .transfer_begin_n,
    .device_serial_out, .req, .stall, .h2d_msg(h2d), .host_ready_n,
    .host_msg_pending_n, .device_serial_in, .rx_word);
  always #2.5 pclk = ~pclk;
  always @(negedge serial_clk) nfall++;
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      mismatches++;
      close_out;
    end
  endtask : apb
  // Bounded wait on the frame line or the suspend flag
  task automatic wt(input bit s, input logic v);
    int i;
    i = 0;
    while ((s ? low_power : transfer_begin_n) !== v) begin
      @(posedge pclk);
      i++;
      if (i > 9000) begin
        mismatches++;
        close_out;
      end
    end
  endtask : wt
  task automatic send(input ssml_row_t r);
    apb(1, OFS_TX_HDR, {16'h0, r.id, r.len});
    for (int j = 0; j < 3; j++) apb(1, OFS_TXD0 + 8'(4 * j), r.d[32*j+:32]);
    apb(1, OFS_CTRL, 32'h1);
  endtask : send
  // Last five bytes of the device message for one row
  function automatic logic [39:0] last5(input ssml_row_t r);
    logic [7:0] b[16];
    int n;
    n = r.len + 4;
    b = '{default: 8'h00};
    {b[2], b[1], b[0]} = {r.id, r.len, SYNC_D2H};
    for (int i = 0; i < n - 1; i++) begin
      if (i > 2) b[i] = r.d[8*i-24+:8];
      b[n-1] ^= b[i];
    end
    for (int i = 0; i < 5; i++) last5[8*i+:8] = b[n-5+i];
  endfunction : last5
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({serial_clk, device_serial_out, transfer_begin_n, low_power},
        4'hE);
    apb(0, OFS_STATUS, 0);
    chk(q, 32'h08);
    apb(0, 8'h28, 0);
    chk({err, q}, {1'b1, 32'h0});
    foreach (rows[i]) begin
      flow_mode_select <= rows[i].fl;
      stall <= (i == 0);
      nfall = 0;
      send(rows[i]);
      wt(0, 0);
      if (i == 0) begin
        repeat (300) @(posedge pclk);
        chk(nfall, 0);
        stall <= 0;
      end
      if (i == 1) begin
        repeat (200) @(posedge pclk);
        stall <= 1;
        repeat (50) @(posedge pclk);
        nfall = 0;
        repeat (200) @(posedge pclk);
        chk(nfall, 0);
        stall <= 0;
      end
      wt(0, 1);
      chk(rx_word[47:8], last5(rows[i]));
    end
    for (int g = 0; g < 3; g++) begin
      h2d <= (g == 0) ? 32'hEE014B01 : (g == 1) ? 32'hEF014B01 : 32'h0A;
      apb(1, OFS_STATUS, 32'h6);
      req <= 1;
      wt(0, 0);
      req <= 0;
      wt(0, 1);
      chk(rx_word[47:40], SYNC_H2D);
      apb(0, OFS_STATUS, 0);
      chk(q[2:1], g ? 2'b10 : 2'b01);
      apb(0, OFS_RX_HDR, 0);
      chk(q[15:0], (g == 2) ? 16'h4B0A : 16'h4B01);
      apb(0, OFS_RXD0, 0);
      chk(q[7:0], 8'h01);
    end
    port_mode_select <= 0;
    send(rows[0]);
    repeat (100) @(posedge pclk);
    chk(transfer_begin_n, 1'b1);
    suspend_in <= 1;
    repeat (40) @(posedge pclk);
    apb(0, OFS_TX_HDR, 0);
    chk({low_power, q}, 33'h0);
    port_mode_select <= 1;
    suspend_in <= 0;
    send(rows[2]);
    wt(0, 0);
    suspend_in <= 1;
    repeat (40) @(posedge pclk);
    chk({low_power, transfer_begin_n}, 2'b00);
    suspend_in <= 0;
    repeat (4) @(posedge pclk);
    sleep_in <= 1;
    suspend_in <= 1;
    wt(1, 1);
    @(posedge pclk);
    chk({transfer_begin_n, serial_clk}, 2'b11);
    suspend_in <= 0;
    repeat (40) @(posedge pclk);
    chk(low_power, 1'b1);
    sleep_in <= 0;
    wt(1, 0);
    apb(0, OFS_TX_HDR, 0);
    chk(q, 32'h0);
    close_out;
  end
endmodule : ssml_link_tb
